/* hw/dpg_gpio.sv */
// Purpose: Two 8-bit GPIO ports shared with the multiplexed external bus
// Assumes: AHB-Lite slave, zero wait states, word accesses
// Notes:   Function
`timescale 1ns/1ns
`default_nettype none
module dpg_gpio
#(
    parameter int WIDTH = 8
)
(
    // Clock and reset
    input  wire logic             mclk_in,
    input  wire logic             rst_n_in,
    // AHB-Lite slave
    input  wire logic             hsel_in,
    input  wire logic [31:0]      haddr_in,
    input  wire logic [1:0]       htrans_in,
    input  wire logic             hwrite_in,
    input  wire logic [2:0]       hsize_in,
    input  wire logic [31:0]      hwdata_in,
    input  wire logic             hready_in,
    output var  logic [31:0]      hrdata_out,
    output var  logic             hreadyout_out,
    output var  logic             hresp_out,
    // External bus controller
    input  wire logic             ext_access_in,
    input  wire logic [WIDTH-1:0] muxed_addr_data_low_in,
    input  wire logic [WIDTH-1:0] muxed_addr_data_high_in,
    input  wire logic             muxed_addr_data_oe_in,
    input  wire logic [WIDTH-1:0] address_mid_byte_in,
    // Low port pins
    input  wire logic [WIDTH-1:0] low_pin_in,
    output var  logic [WIDTH-1:0] low_pin_out,
    output var  logic [WIDTH-1:0] low_pin_oe_out,
    // High port pins
    input  wire logic [WIDTH-1:0] high_pin_in,
    output logic      [WIDTH-1:0] high_pin_out,
    output logic      [WIDTH-1:0] high_pin_oe_out
);
    // ********************************
    // Reset release
    // ********************************
    logic rst_n;

    dpg_reset_sync u_rst
    (
        .mclk_in   (mclk_in),
        .rst_n_in  (rst_n_in),
        .rst_n_out (rst_n)
    );

    // ********************************
    // Bus address phase
    // ********************************
    logic [WIDTH-1:0]              low_port_direction_reg;
    logic [WIDTH-1:0]              high_port_direction_reg;
    logic [WIDTH-1:0]              high_port_function_reg;
    logic [WIDTH-1:0]              low_latch_reg;
    logic [WIDTH-1:0]              high_latch_reg;
    logic                          wr_pend_reg;
    logic [dpg_pkg::ADDR_W-1:0]    wr_addr_reg;

    function automatic logic is_reg(input logic [dpg_pkg::ADDR_W-1:0] a, input logic [2:0] idx);
        is_reg = (a == {idx, dpg_pkg::WORD_LSB});
    endfunction

    wire addr_phase = hsel_in && hready_in && (htrans_in == dpg_pkg::HTRANS_NONSEQ ||
                                               htrans_in == dpg_pkg::HTRANS_SEQ);
    wire word_ok    = (hsize_in == dpg_pkg::HSIZE_WORD) &&
                      (haddr_in[31:dpg_pkg::ADDR_W] == '0);
    wire [dpg_pkg::ADDR_W-1:0] ra = haddr_in[dpg_pkg::ADDR_W-1:0];

    // Pin levels are read, never latches; write-only registers read zero
    wire [WIDTH-1:0] rd_byte = is_reg(ra, dpg_pkg::IDX_LOW_DATA)  ? low_pin_in :
                               is_reg(ra, dpg_pkg::IDX_HIGH_DATA) ? high_pin_in :
                               '0;
    wire [31:0] rd_next = (addr_phase && !hwrite_in && word_ok) ? {{(32-WIDTH){1'b0}}, rd_byte} : 32'h0;

    wire wr_low_data  = wr_pend_reg && is_reg(wr_addr_reg, dpg_pkg::IDX_LOW_DATA);
    wire wr_high_data = wr_pend_reg && is_reg(wr_addr_reg, dpg_pkg::IDX_HIGH_DATA);
    wire wr_low_dir   = wr_pend_reg && is_reg(wr_addr_reg, dpg_pkg::IDX_LOW_DIR);
    wire wr_high_dir  = wr_pend_reg && is_reg(wr_addr_reg, dpg_pkg::IDX_HIGH_DIR);
    wire wr_high_func = wr_pend_reg && is_reg(wr_addr_reg, dpg_pkg::IDX_HIGH_FUNC);
    wire [WIDTH-1:0] wbyte = hwdata_in[WIDTH-1:0];

    // ********************************
    // Bus state
    // ********************************
    always_ff @(posedge mclk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_pend_reg   <= 1'b0;
            wr_addr_reg   <= '0;
            hrdata_out    <= 32'h0;
            hreadyout_out <= 1'b0;
            hresp_out     <= 1'b0;
        end
        else
        begin
            wr_pend_reg   <= addr_phase && hwrite_in && word_ok;
            wr_addr_reg   <= ra;
            hrdata_out    <= rd_next;
            hreadyout_out <= 1'b1;
            hresp_out     <= 1'b0;
        end
    end

    // ********************************
    // Configuration registers
    // ********************************
    // External access wins over a software write to the low direction register in the same cycle
    always_ff @(posedge mclk_in or negedge rst_n)
    begin
        if (!rst_n)
            low_port_direction_reg <= dpg_pkg::RST_LOW_DIR;
        else if (ext_access_in)
            low_port_direction_reg <= dpg_pkg::RST_LOW_DIR;
        else if (wr_low_dir)
            low_port_direction_reg <= wbyte;
    end

    always_ff @(posedge mclk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            high_port_direction_reg <= dpg_pkg::RST_HIGH_DIR;
            high_port_function_reg  <= dpg_pkg::RST_HIGH_FUNC;
            high_latch_reg          <= dpg_pkg::RST_HIGH_LAT;
        end
        else
        begin
            if (wr_high_dir)
                high_port_direction_reg <= wbyte;
            if (wr_high_func)
                high_port_function_reg <= wbyte;
            if (wr_high_data)
                high_latch_reg <= wbyte;
        end
    end

    // Low latch keeps no reset so its content is unspecified after reset
    always_ff @(posedge mclk_in)
    begin
        if (wr_low_data)
            low_latch_reg <= wbyte;
    end

    // ********************************
    // Low port pins
    // ********************************
    wire [WIDTH-1:0] low_val_next = ext_access_in ? muxed_addr_data_low_in : low_latch_reg;
    wire [WIDTH-1:0] low_oe_next  = ext_access_in ? {WIDTH{muxed_addr_data_oe_in}}
                                                  : low_port_direction_reg;

    always_ff @(posedge mclk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            low_pin_out    <= dpg_pkg::RST_LOW_LAT;
            low_pin_oe_out <= dpg_pkg::RST_LOW_DIR;
        end
        else
        begin
            low_pin_out    <= low_val_next;
            low_pin_oe_out <= low_oe_next;
        end
    end

    // ********************************
    // High port pins
    // ********************************
    dpg_pin_mux #(.WIDTH(WIDTH)) u_high
    (
        .mclk_in    (mclk_in),
        .rst_n_in   (rst_n),
        .func_in    (high_port_function_reg),
        .dir_in     (high_port_direction_reg),
        .latch_in   (high_latch_reg),
        .ad_out_in  (muxed_addr_data_high_in),
        .ad_oe_in   (muxed_addr_data_oe_in),
        .addr_in    (address_mid_byte_in),
        .pin_out    (high_pin_out),
        .pin_oe_out (high_pin_oe_out)
    );
endmodule
`default_nettype wire

/* hw/dpg_pin_mux.sv */
// Purpose: Per-pin selection for the high port
// Assumes: Mode is {function bit, direction bit}
// Notes:   Registered so top outputs come from flip-flops
`timescale 1ns/1ns
`default_nettype none
module dpg_pin_mux
#(
    parameter int WIDTH = 8
)
(
    // Clock and reset
    input  wire logic             mclk_in,
    input  wire logic             rst_n_in,
    // Configuration
    input  wire logic [WIDTH-1:0] func_in,
    input  wire logic [WIDTH-1:0] dir_in,
    input  wire logic [WIDTH-1:0] latch_in,
    // Bus controller
    input  wire logic [WIDTH-1:0] ad_out_in,
    input  wire logic             ad_oe_in,
    input  wire logic [WIDTH-1:0] addr_in,
    // Pin drive
    output var  logic [WIDTH-1:0] pin_out,
    output var  logic [WIDTH-1:0] pin_oe_out
);
    logic [WIDTH-1:0] val_next;
    logic [WIDTH-1:0] oe_next;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1)
        begin : g_pin
            wire dpg_pkg::dpg_mode_e mode = dpg_pkg::dpg_mode_e'({func_in[i], dir_in[i]});
            // Bus modes take value from the controller; AD drives per ad_oe_in, ADDR always drives
            assign val_next[i] = (mode == dpg_pkg::DPG_OUT)  ? latch_in[i] :
                                 (mode == dpg_pkg::DPG_AD)   ? ad_out_in[i] :
                                 (mode == dpg_pkg::DPG_ADDR) ? addr_in[i] : 1'b0;
            assign oe_next[i]  = (mode == dpg_pkg::DPG_OUT)  ||
                                 (mode == dpg_pkg::DPG_ADDR) ||
                                 ((mode == dpg_pkg::DPG_AD) && ad_oe_in);
        end
    endgenerate

    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            pin_out    <= '0;
            pin_oe_out <= '0;
        end
        else
        begin
            pin_out    <= val_next;
            pin_oe_out <= oe_next;
        end
    end
endmodule
`default_nettype wire

/* hw/dpg_pkg.sv */
// Purpose: Constants shared by the dual port bus mux GPIO block
// Assumes: AHB-Lite register bus, 32-bit data
// Notes:   Printed offsets are register indexes; byte address is four times the index
package dpg_pkg;
    // ********************************
    // Register indexes and addresses
    // ********************************
    localparam logic [2:0] IDX_LOW_DATA  = 3'h0;
    localparam logic [2:0] IDX_HIGH_DATA = 3'h1;
    localparam logic [2:0] IDX_LOW_DIR   = 3'h2;
    localparam logic [2:0] IDX_HIGH_DIR  = 3'h4;
    localparam logic [2:0] IDX_HIGH_FUNC = 3'h5;
    localparam int         ADDR_W        = 5;
    localparam logic [1:0] WORD_LSB      = 2'h0;

    // ********************************
    // Reset values
    // ********************************
    localparam logic [7:0] RST_LOW_DIR   = 8'h00;
    localparam logic [7:0] RST_HIGH_DIR  = 8'h00;
    localparam logic [7:0] RST_HIGH_FUNC = 8'h00;
    localparam logic [7:0] RST_HIGH_LAT  = 8'h00;
    localparam logic [7:0] RST_LOW_LAT   = 8'h00;

    // ********************************
    // Bus encodings
    // ********************************
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ    = 2'h3;
    localparam logic [2:0] HSIZE_WORD    = 3'h2;

    // High pin modes, {function, direction}
    typedef enum logic [1:0] {
        DPG_IN   = 2'b00,
        DPG_OUT  = 2'b01,
        DPG_AD   = 2'b10,
        DPG_ADDR = 2'b11
    } dpg_mode_e;
endpackage

/* hw/dpg_reset_sync.sv */
// Purpose: Two-stage release of the asynchronous reset
// Assumes: Active-low reset input
// Notes:   Assertion is immediate, release is clocked
`timescale 1ns/1ns
`default_nettype none
module dpg_reset_sync
(
    // Clock and raw reset
    input  wire logic mclk_in,
    input  wire logic rst_n_in,
    // Released reset
    output var  logic rst_n_out
);
    logic stage_reg;

    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            stage_reg <= 1'b0;
            rst_n_out <= 1'b0;
        end
        else
        begin
            stage_reg <= 1'b1;
            rst_n_out <= stage_reg;
        end
    end
endmodule
`default_nettype wire

/* verif/dpg_gpio_properties.sv */
// Purpose: Port-level checks for dpg_gpio
// Assumes: Zero-wait bus, registered pins
// Notes:   Bound to every dpg_gpio
`timescale 1ns/1ns
`default_nettype none
module dpg_gpio_checker
#(
    parameter int WIDTH = 8
)
(
    // Clock, reset and bus
    input wire logic             mclk_in,
    input wire logic             rst_n_in,
    input wire logic             hsel_in,
    input wire logic [31:0]      haddr_in,
    input wire logic [1:0]       htrans_in,
    input wire logic             hwrite_in,
    input wire logic [2:0]       hsize_in,
    input wire logic             hready_in,
    input wire logic [31:0]      hrdata_out,
    input wire logic             hreadyout_out,
    // Bus controller and pins
    input wire logic             ext_access_in,
    input wire logic [WIDTH-1:0] muxed_addr_data_low_in,
    input wire logic             muxed_addr_data_oe_in,
    input wire logic [WIDTH-1:0] low_pin_in,
    input wire logic [WIDTH-1:0] low_pin_out,
    input wire logic [WIDTH-1:0] low_pin_oe_out,
    input wire logic [WIDTH-1:0] high_pin_in,
    input wire logic [WIDTH-1:0] high_pin_oe_out
);
    // **********
    // Properties
    // **********
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!rst_n_in);
    sequence rd_s;
        hsel_in && hready_in && htrans_in[1] && !hwrite_in && hsize_in == dpg_pkg::HSIZE_WORD;
    endsequence
    sequence ext_end_s;
        ext_access_in ##1 !ext_access_in;
    endsequence
    AST_EXT_LOW:
        assert property (ext_access_in |=> low_pin_out == $past(muxed_addr_data_low_in)
            && low_pin_oe_out == {WIDTH{$past(muxed_addr_data_oe_in)}}) else $error("low pins off bus");
    AST_EXT_CLR:
        assert property (ext_end_s |=> low_pin_oe_out == '0) else $error("low direction kept");
    AST_RST_LOW:
        assert property ($rose(hreadyout_out) |-> low_pin_oe_out == '0) else $error("low pin driven");
    AST_RST_HIGH:
        assert property ($rose(hreadyout_out) |-> high_pin_oe_out == '0) else $error("high pin driven");
    AST_LOW_READ:
        assert property (rd_s ##0 haddr_in == 32'h0 |=> hrdata_out == 32'($past(low_pin_in)))
            else $error("low read not pins");
    AST_HIGH_READ:
        assert property (rd_s ##0 haddr_in == 32'h4 |=> hrdata_out == 32'($past(high_pin_in)))
            else $error("high read not pins");
    AST_WO_READ:
        assert property (rd_s ##0 haddr_in inside {32'h8, 32'h10, 32'h14} |=> hrdata_out == 32'h0)
            else $error("write-only read nonzero");
    AST_LOW_HOLD:
        assert property ((hreadyout_out && !hsel_in && !ext_access_in)[*3] |=> $stable(low_pin_oe_out)
            && $stable(low_pin_out & low_pin_oe_out)) else $error("low pins moved");
endmodule
bind dpg_gpio dpg_gpio_checker #(.WIDTH(WIDTH)) chk_u (.mclk_in, .rst_n_in, .hsel_in, .haddr_in,
    .htrans_in, .hwrite_in, .hsize_in, .hready_in, .hrdata_out, .hreadyout_out, .ext_access_in,
    .muxed_addr_data_low_in, .muxed_addr_data_oe_in, .low_pin_in, .low_pin_out, .low_pin_oe_out,
    .high_pin_in, .high_pin_oe_out);
`default_nettype wire

/* verif/dpg_pin_model.sv */
// Purpose: Far-side devices on one port
// Assumes: Far side drives every pin the port releases
// Notes:   Port drive wins where enabled
`timescale 1ns/1ns
`default_nettype none
module dpg_pin_model
(
    // Port side
    input  wire logic [7:0] pin_in,
    input  wire logic [7:0] oe_in,
    // Far side
    input  wire logic [7:0] drive_in,
    output var  logic [7:0] level_out
);
    // Masking keeps an undefined latch off released pins
    assign level_out = (pin_in & oe_in) | (drive_in & ~oe_in);
endmodule
`default_nettype wire

/* verif/tb_dual_port_bus_mux_gpio.sv */
// Purpose: Self-checking bench for dpg_gpio
// Assumes: Single slave, hready from hreadyout
// Notes:   Reads checked from a queue
`timescale 1ns/1ns
`default_nettype none
module tb_dual_port_bus_mux_gpio;
    localparam logic [7:0] LDRV = 8'h5a;
    localparam logic [7:0] HDRV = 8'hc3;
    logic        mclk_in = 1'b0, rst_n_in = 1'b0, hsel_in = 1'b0, hwrite_in = 1'b0, rd_pend = 1'b0;
    logic        ext_access_in = 1'b0, muxed_addr_data_oe_in = 1'b0, hreadyout_out, hresp_out;
    logic [31:0] haddr_in = 32'h0, hwdata_in = 32'h0, hrdata_out, seed = 32'h79c6e36d;
    logic [1:0]  htrans_in = 2'h0;
    logic [2:0]  hsize_in = 3'h2;
    logic [7:0]  muxed_addr_data_low_in = 8'h00, muxed_addr_data_high_in = 8'h00;
    logic [7:0]  address_mid_byte_in = 8'h00, low_pin_in, low_pin_out, low_pin_oe_out;
    logic [7:0]  high_pin_in, high_pin_out, high_pin_oe_out, lat, f, d, eo, ev;
    logic [31:0] wo[4] = '{32'h8, 32'h10, 32'h14, 32'hc};
    logic [31:0] exp_q[$];
    int          err_count = 0, check_count = 0;
    always #4 mclk_in = ~mclk_in;
    dpg_gpio dut_u (.mclk_in, .rst_n_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in, .hsize_in,
        .hwdata_in, .hready_in(hreadyout_out), .hrdata_out, .hreadyout_out, .hresp_out, .ext_access_in,
        .muxed_addr_data_low_in, .muxed_addr_data_high_in, .muxed_addr_data_oe_in, .address_mid_byte_in,
        .low_pin_in, .low_pin_out, .low_pin_oe_out, .high_pin_in, .high_pin_out, .high_pin_oe_out);
    dpg_pin_model lo_m (.pin_in(low_pin_out), .oe_in(low_pin_oe_out), .drive_in(LDRV), .level_out(low_pin_in));
    dpg_pin_model hi_m (.pin_in(high_pin_out), .oe_in(high_pin_oe_out), .drive_in(HDRV), .level_out(high_pin_in));
    // *****
    // Tasks
    // *****
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Read data goes to the queue; hold everything until hready
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] dat);
        @(posedge mclk_in);
        hsel_in <= 1'b1;
        haddr_in <= a;
        htrans_in <= dpg_pkg::HTRANS_NONSEQ;
        hwrite_in <= w;
        if (!w)
            exp_q.push_back(dat);
        do @(posedge mclk_in); while (hreadyout_out !== 1'b1);
        hsel_in <= 1'b0;
        htrans_in <= 2'h0;
        hwdata_in <= dat;
        do @(posedge mclk_in); while (hreadyout_out !== 1'b1);
    endtask
    task automatic settle;
        repeat (2) @(posedge mclk_in);
        #1;
    endtask
    always @(posedge mclk_in)
    begin
        if (rd_pend && hreadyout_out === 1'b1 && exp_q.size() > 0)
        begin
            chk(hrdata_out, exp_q.pop_front());
            chk(32'(hresp_out), 32'h0);
        end
        if (hreadyout_out === 1'b1)
            rd_pend <= hsel_in && htrans_in[1] && !hwrite_in;
    end
    initial
    begin
        #20000;
        err_count++;
        end_sim();
    end
    // *********
    // Scenarios
    // *********
    initial
    begin
        repeat (12) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        do @(posedge mclk_in); while (hreadyout_out !== 1'b1);
        #1;
        chk(32'(low_pin_oe_out), 32'h0);
        chk(32'(high_pin_oe_out), 32'h0);
        xfer(1'b0, 32'h0, 32'(LDRV));
        xfer(1'b0, 32'h4, 32'(HDRV));
        seed = lfsr(seed);
        lat = seed[7:0];
        xfer(1'b1, 32'h0, 32'(lat));
        xfer(1'b1, 32'h8, 32'hf0);
        xfer(1'b1, 32'h28, 32'hff);
        settle();
        chk(32'(low_pin_oe_out), 32'hf0);
        chk(32'(low_pin_out & 8'hf0), 32'(lat & 8'hf0));
        xfer(1'b0, 32'h0, 32'((lat & 8'hf0) | (LDRV & 8'h0f)));
        // Non-word size is refused and reads zero
        hsize_in <= 3'h0;
        xfer(1'b0, 32'h0, 32'h0);
        hsize_in <= dpg_pkg::HSIZE_WORD;
        for (int i = 0; i < 4; i++)
            xfer(1'b0, wo[i], 32'h0);
        for (int k = 0; k < 2; k++)
        begin
            seed = lfsr(seed);
            f = k ? seed[7:0] : 8'hcc;
            d = k ? seed[15:8] : 8'haa;
            lat = seed[23:16];
            @(posedge mclk_in);
            muxed_addr_data_high_in <= seed[31:24];
            address_mid_byte_in <= ~seed[15:8];
            muxed_addr_data_oe_in <= k[0];
            xfer(1'b1, 32'h4, 32'(lat));
            xfer(1'b1, 32'h10, 32'(d));
            xfer(1'b1, 32'h14, 32'(f));
            settle();
            eo = (f & (d | {8{muxed_addr_data_oe_in}})) | (~f & d);
            ev = (f & ((d & address_mid_byte_in) | (~d & muxed_addr_data_high_in))) | (~f & lat);
            chk(32'(high_pin_oe_out), 32'(eo));
            chk(32'(high_pin_out & eo), 32'(ev & eo));
            xfer(1'b0, 32'h4, 32'(ev & eo | HDRV & ~eo));
        end
        xfer(1'b1, 32'h8, 32'hff);
        @(posedge mclk_in);
        ext_access_in <= 1'b1;
        muxed_addr_data_low_in <= seed[15:8];
        @(posedge mclk_in);
        ext_access_in <= 1'b0;
        #1;
        chk(32'(low_pin_out), 32'(seed[15:8]));
        chk(32'(low_pin_oe_out), 32'hff);
        @(posedge mclk_in);
        #1;
        chk(32'(low_pin_oe_out), 32'h0);
        xfer(1'b0, 32'h0, 32'(LDRV));
        @(posedge mclk_in);
        // Mid-run reset must clear high latch and configuration
        rst_n_in <= 1'b0;
        repeat (3) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        do @(posedge mclk_in); while (hreadyout_out !== 1'b1);
        #1;
        chk(32'({low_pin_oe_out, high_pin_oe_out}), 32'h0);
        xfer(1'b1, 32'h10, 32'hff);
        settle();
        chk(32'(high_pin_oe_out), 32'hff);
        chk(32'(high_pin_out), 32'h0);
        @(posedge mclk_in);
        end_sim();
    end
endmodule
`default_nettype wire
